/* File: src/wddc_channel.sv */
`timescale 1ns/1ns
// Behaviour
// - NCO and quadrature mixers shift band down
// - One to four half-bands, each halving rate
// - Optional gain of 0 dB or 6 dB
// - Real output via fs/4 mix and filtering
// - Real mode ratios 1, 2, 4, 8
// - Complex mode ratios 2, 4, 8, 16
// - Slower channels repeat samples to chip rate
// - Each pair repeated D times at ratio one
// - Real mode: only I output valid
// - Control bit 3 selects real output
module wddc_channel (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic signed [15:0] adc_i_i,
    input wire logic signed [15:0] adc_q_i,
    output logic out_valid_o,
    output logic signed [15:0] out_i_o,
    output logic signed [15:0] out_q_o,
    output logic out_q_valid_o
);
    typedef struct packed {
        logic [7:0] chip_dec;
        logic [7:0] ctrl;
        logic [11:0] nco_freq;
        logic soft_rst;
        logic [7:0] rdata;
        logic [11:0] phase;
        wddc_pkg::wddc_iq_t mix;
        logic mix_v;
        logic c2r_par;
        logic col_cnt;
        logic col_rdy;
        wddc_pkg::wddc_iq_t col0;
        wddc_pkg::wddc_iq_t col1;
        wddc_pkg::wddc_iq_t shown0;
        wddc_pkg::wddc_iq_t shown1;
        logic started;
        logic [4:0] div;
        logic [5:0] seq;
        logic out_v;
        wddc_pkg::wddc_iq_t out;
        logic out_qv;
    } wddc_top_state_t;

    wddc_top_state_t s;
    wddc_top_state_t next_s;

    wddc_pkg::wddc_iq_t hb_d [0:4];
    logic hb_v [0:4];
    wddc_pkg::wddc_iq_t sel;
    wddc_pkg::wddc_iq_t g;
    logic sel_v;
    logic c2r;
    logic [2:0] ld;
    logic [2:0] lc;
    logic [2:0] rl;
    logic tick;
    logic [5:0] seq_last;
    logic pair_done;

    function automatic logic signed [15:0] wddc_sin(input logic [11:0] p);
        logic [3:0] k;
        logic signed [15:0] m;
        k = p[10] ? 4'(4'd8 - {1'b0, p[9:7]}) : {1'b0, p[9:7]};
        m = wddc_pkg::SIN_LUT[k];
        return p[11] ? -m : m;
    endfunction

    function automatic logic signed [15:0] wddc_dbl(
        input logic signed [15:0] x);
        if (x[15] != x[14]) begin
            return x[15] ? 16'sh8000 : 16'sh7fff;
        end
        return {x[14:0], 1'b0};
    endfunction

    assign hb_d[0] = s.mix;
    assign hb_v[0] = s.mix_v;

    for (genvar k = 0; k < wddc_pkg::STAGES; k++) begin : g_hb
        wddc_halfband u_hb (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .clear_i(s.soft_rst),
            .in_valid_i(hb_v[k]),
            .in_i(hb_d[k]),
            .out_valid_o(hb_v[k+1]),
            .out_o(hb_d[k+1])
        );
    end

    always_comb begin
        logic [2:0] n;
        logic signed [31:0] p_ic;
        logic signed [31:0] p_qs;
        logic signed [31:0] p_qc;
        logic signed [31:0] p_is;
        logic signed [32:0] acc_i;
        logic signed [32:0] acc_q;
        logic signed [15:0] cs;
        logic signed [15:0] sn;
        // Mixer: (I + jQ) * (cos - j sin)
        cs = wddc_sin(12'(s.phase + wddc_pkg::NCO_QUARTER));
        sn = wddc_sin(s.phase);
        p_ic = 32'(adc_i_i) * 32'(cs);
        p_qs = 32'(adc_q_i) * 32'(sn);
        p_qc = 32'(adc_q_i) * 32'(cs);
        p_is = 32'(adc_i_i) * 32'(sn);
        acc_i = 33'(p_ic) + 33'(p_qs);
        acc_q = 33'(p_qc) - 33'(p_is);
        n = 3'(s.ctrl[wddc_pkg::CTRL_STAGES_LSB +: 2]) + 3'd1;
        c2r = s.ctrl[wddc_pkg::CTRL_C2R_BIT];
        sel = hb_d[n];
        sel_v = hb_v[n];
        ld = c2r ? 3'(n - 3'd1) : n;
        lc = (s.chip_dec[2:0] > 3'(wddc_pkg::CHIP_DEC_MAX)) ?
            3'(wddc_pkg::CHIP_DEC_MAX) : s.chip_dec[2:0];
        rl = (ld > lc) ? 3'(ld - lc) : 3'd0;
        seq_last = 6'((6'd2 << rl) - 6'd1);
        // At or past the limit, so a lowered chip ratio ticks at once
        tick = (s.div >= 5'((5'd1 << lc) - 5'd1));
        g = sel;
        if (s.ctrl[wddc_pkg::CTRL_GAIN_BIT]) begin
            g.i = wddc_dbl(sel.i);
            g.q = wddc_dbl(sel.q);
        end
        pair_done = sel_v && !s.soft_rst && (c2r || s.col_cnt);

        next_s = s;
        next_s.soft_rst = 1'b0;
        next_s.rdata = 8'h00;
        next_s.out_v = 1'b0;
        next_s.out_qv = !c2r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                wddc_pkg::CHIP_DEC_ADDR: next_s.chip_dec = reg_wdata_i;
                wddc_pkg::CTRL_ADDR: next_s.ctrl = reg_wdata_i;
                wddc_pkg::NCO_LO_ADDR: next_s.nco_freq[7:0] = reg_wdata_i;
                wddc_pkg::NCO_HI_ADDR: next_s.nco_freq[11:8] = reg_wdata_i[3:0];
                wddc_pkg::SOFT_RST_ADDR:
                    next_s.soft_rst = reg_wdata_i[wddc_pkg::SOFT_RST_BIT];
                default: next_s.soft_rst = 1'b0;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                wddc_pkg::CHIP_DEC_ADDR: next_s.rdata = s.chip_dec;
                wddc_pkg::CTRL_ADDR: next_s.rdata = s.ctrl;
                wddc_pkg::NCO_LO_ADDR: next_s.rdata = s.nco_freq[7:0];
                wddc_pkg::NCO_HI_ADDR: next_s.rdata = {4'h0, s.nco_freq[11:8]};
                wddc_pkg::STATUS_ADDR:
                    next_s.rdata = {3'h0, s.col_rdy, s.started, ld};
                default: next_s.rdata = 8'h00;
            endcase
        end

        next_s.mix_v = 1'b1;
        if (s.ctrl[wddc_pkg::CTRL_NCO_EN_BIT]) begin
            next_s.phase = 12'(s.phase + s.nco_freq);
            next_s.mix.i = acc_i[30:15];
            next_s.mix.q = acc_q[30:15];
        end else begin
            next_s.mix.i = adc_i_i;
            next_s.mix.q = adc_q_i;
        end

        // Output pacing and pair repetition at the chip rate
        if (tick) begin
            next_s.div = 5'h00;
            if (!s.started) begin
                if (s.col_rdy) begin
                    next_s.started = 1'b1;
                    next_s.shown0 = s.col0;
                    next_s.shown1 = s.col1;
                    next_s.col_rdy = 1'b0;
                    next_s.seq = 6'h00;
                end
            end else begin
                next_s.out_v = 1'b1;
                next_s.out = s.seq[0] ? s.shown1 : s.shown0;
                next_s.seq = 6'(s.seq + 6'd1);
                if (s.seq >= seq_last) begin
                    next_s.seq = 6'h00;
                    if (s.col_rdy) begin
                        next_s.shown0 = s.col0;
                        next_s.shown1 = s.col1;
                        next_s.col_rdy = 1'b0;
                    end
                end
            end
        end else begin
            next_s.div = 5'(s.div + 5'd1);
        end
        if (c2r) begin
            next_s.out.q = 16'sh0000;
        end

        // Collect a pair; a new pair wins over the load that clears it
        if (sel_v) begin
            if (c2r) begin
                next_s.c2r_par = ~s.c2r_par;
                next_s.col0 = '0;
                next_s.col1 = '0;
                next_s.col0.i = s.c2r_par ? -g.i : g.i;
                next_s.col1.i = s.c2r_par ? g.q : -g.q;
                next_s.col_rdy = 1'b1;
            end else if (!s.col_cnt) begin
                next_s.col0 = g;
                next_s.col_cnt = 1'b1;
            end else begin
                next_s.col1 = g;
                next_s.col_cnt = 1'b0;
                next_s.col_rdy = 1'b1;
            end
        end

        if (s.soft_rst) begin
            next_s.phase = wddc_pkg::NCO_RST;
            // Drop an emission of the old stream decided in this cycle
            next_s.out_v = 1'b0;
            next_s.mix_v = 1'b0;
            next_s.c2r_par = 1'b0;
            next_s.col_cnt = 1'b0;
            next_s.col_rdy = 1'b0;
            next_s.started = 1'b0;
            next_s.div = 5'h00;
            next_s.seq = 6'h00;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.chip_dec <= wddc_pkg::CHIP_DEC_RST;
            s.ctrl <= wddc_pkg::CTRL_RST;
            s.nco_freq <= wddc_pkg::NCO_RST;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign out_valid_o = s.out_v;
    assign out_i_o = s.out.i;
    assign out_q_o = s.out.q;
    assign out_q_valid_o = s.out_qv;

    // Clocks between completed pairs, for the rate check only
    logic [6:0] gap;
    logic gap_ok;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= 7'h00;
            gap_ok <= 1'b0;
        end else if (s.soft_rst || reg_wr_i) begin
            gap <= 7'h00;
            gap_ok <= 1'b0;
        end else if (pair_done) begin
            gap <= 7'h01;
            gap_ok <= 1'b1;
        end else begin
            gap <= 7'(gap + 7'd1);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_mix_bypass;
        !s.ctrl[wddc_pkg::CTRL_NCO_EN_BIT] |=>
            s.mix.i == $past(adc_i_i) && s.mix.q == $past(adc_q_i);
    endproperty
    a_mix_bypass: assert property (p_mix_bypass)
        else $error("mixer not bypassed with oscillator off");

    property p_gain;
        s.ctrl[wddc_pkg::CTRL_GAIN_BIT] && sel.i[15] == sel.i[14] |->
            g.i == {sel.i[14:0], 1'b0};
    endproperty
    a_gain: assert property (p_gain)
        else $error("6 dB gain not applied");

    property p_c2r_fill;
        sel_v && c2r && !s.c2r_par && !s.soft_rst |=>
            s.col_rdy && s.col0.i == $past(g.i) && s.col1.i == -$past(g.q);
    endproperty
    a_c2r_fill: assert property (p_c2r_fill)
        else $error("fs/4 real conversion wrong");

    property p_pair_rate;
        pair_done && gap_ok && !reg_wr_i |-> gap == 7'(7'd2 << ld);
    endproperty
    a_pair_rate: assert property (p_pair_rate)
        else $error("channel decimation ratio wrong");

    sequence s_tick_emit;
        tick && s.started && !s.soft_rst;
    endsequence
    property p_emit;
        s_tick_emit |=> s.out_v && s.out.i ==
            ($past(s.seq[0]) ? $past(s.shown1.i) : $past(s.shown0.i));
    endproperty
    a_emit: assert property (p_emit)
        else $error("repeated pair emitted out of order");

    property p_rate_one;
        s.started && lc == 3'd0 && !s.soft_rst |=> s.out_v;
    endproperty
    a_rate_one: assert property (p_rate_one)
        else $error("missing output at chip ratio one");

    property p_q_invalid;
        c2r && $past(c2r) |-> !s.out_qv && s.out.q == 16'sh0000;
    endproperty
    a_q_invalid: assert property (p_q_invalid)
        else $error("quadrature output valid in real mode");

    sequence s_soft;
        s.soft_rst;
    endsequence
    property p_soft;
        s_soft |=> s.phase == 12'h000 && !s.started && !s.col_rdy
            && !s.out_v ##1 !s.out_v;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset did not clear channel state");

endmodule

/* File: src/wddc_pkg.sv */
package wddc_pkg;

    localparam int SAMP_W = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NCO_W = 12;
    localparam int STAGES = 4;

    localparam logic [11:0] CHIP_DEC_ADDR = 12'h201;
    localparam logic [11:0] SOFT_RST_ADDR = 12'h300;
    localparam logic [11:0] STATUS_ADDR = 12'h302;
    localparam logic [11:0] CTRL_ADDR = 12'h310;
    localparam logic [11:0] NCO_LO_ADDR = 12'h314;
    localparam logic [11:0] NCO_HI_ADDR = 12'h315;

    localparam int CTRL_STAGES_LSB = 0;
    localparam int CTRL_GAIN_BIT = 2;
    localparam int CTRL_C2R_BIT = 3;
    localparam int CTRL_NCO_EN_BIT = 4;
    localparam int SOFT_RST_BIT = 0;
    localparam int CHIP_DEC_MAX = 4;

    localparam logic [7:0] CHIP_DEC_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h03;
    localparam logic [11:0] NCO_RST = 12'h000;
    localparam logic [11:0] NCO_QUARTER = 12'h400;

    // Quarter-wave sine, 32 steps per turn, full scale 0x7fff
    localparam logic signed [15:0] SIN_LUT [0:8] = '{
        16'sh0000, 16'sh18f9, 16'sh30fb, 16'sh471c, 16'sh5a82,
        16'sh6a6d, 16'sh7641, 16'sh7d8a, 16'sh7fff};

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } wddc_iq_t;

endpackage

/* File: src/wddc_halfband.sv */
`timescale 1ns/1ns
module wddc_halfband (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    input wire wddc_pkg::wddc_iq_t in_i,
    output logic out_valid_o,
    output wddc_pkg::wddc_iq_t out_o
);
    typedef struct packed {
        wddc_pkg::wddc_iq_t d1;
        wddc_pkg::wddc_iq_t d2;
        logic ph;
        logic out_v;
        wddc_pkg::wddc_iq_t out;
    } wddc_hb_state_t;

    wddc_hb_state_t s;
    wddc_hb_state_t next_s;

    function automatic logic signed [15:0] wddc_taps(
        input logic signed [15:0] x0, x1, x2);
        logic signed [17:0] acc;
        acc = 18'(x0) + 18'(x1) + 18'(x1) + 18'(x2);
        return acc[17:2];
    endfunction

    // Taps 1/4 1/2 1/4, output on every second input
    always_comb begin
        next_s = s;
        next_s.out_v = 1'b0;
        if (clear_i) begin
            next_s = '0;
        end else if (in_valid_i) begin
            next_s.d1 = in_i;
            next_s.d2 = s.d1;
            next_s.ph = ~s.ph;
            if (s.ph) begin
                next_s.out_v = 1'b1;
                next_s.out.i = wddc_taps(in_i.i, s.d1.i, s.d2.i);
                next_s.out.q = wddc_taps(in_i.q, s.d1.q, s.d2.q);
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_valid_o = s.out_v;
    assign out_o = s.out;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_hb_halve;
        s.out_v |=> !s.out_v;
    endproperty
    a_hb_halve: assert property (p_hb_halve)
        else $error("half-band produced two outputs in a row");

    property p_hb_clear;
        clear_i |=> !s.ph && !s.out_v && s.d1 == '0;
    endproperty
    a_hb_clear: assert property (p_hb_clear)
        else $error("half-band state not cleared by soft reset");

endmodule

/* File: verification/wddc_framer_model.sv */
`timescale 1ns/1ns
module wddc_framer_model (
    input wire logic ref_clk_i,
    input wire logic flush_i,
    input wire logic valid_i,
    input wire logic signed [15:0] i_i,
    input wire logic signed [15:0] q_i,
    input wire logic q_valid_i
);
    logic [15:0] si[$];
    logic [15:0] sq[$];
    int st[$];
    int cyc = 0;

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (flush_i) begin
            si.delete();
            sq.delete();
            st.delete();
        end else if (valid_i) begin
            si.push_back(i_i);
            // Q lane is recorded as zero while it is flagged invalid
            sq.push_back(q_valid_i ? q_i : 16'h0000);
            st.push_back(cyc);
        end
    end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic signed [15:0] ai = 16'sh0000;
    logic signed [15:0] aq = 16'sh0000;
    logic signed [15:0] dc_i = 16'sh0000;
    logic signed [15:0] dc_q = 16'sh0000;
    logic ramp = 1'b0;
    logic flush = 1'b0;
    logic ov;
    logic signed [15:0] oi;
    logic signed [15:0] oq;
    logic oqv;
    int n_errors = 0;
    int total_checks = 0;

    wddc_channel dut (
        .ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .adc_i_i(ai), .adc_q_i(aq),
        .out_valid_o(ov), .out_i_o(oi), .out_q_o(oq),
        .out_q_valid_o(oqv)
    );

    wddc_framer_model fr (
        .ref_clk_i(clk), .flush_i(flush), .valid_i(ov), .i_i(oi),
        .q_i(oq), .q_valid_i(oqv)
    );

    initial begin
        forever #50 clk = ~clk;
    end

    // Ramp gives every decimated sample a distinct value
    always @(posedge clk) begin
        ai <= ramp ? ai + 16'sd32 : dc_i;
        aq <= ramp ? aq + 16'sd32 : dc_q;
    end

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic soft_rst();
        wr(wddc_pkg::SOFT_RST_ADDR, 8'h01);
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(wddc_pkg::CTRL_ADDR, d);
        chk("ctrl_rst", 16'(d), 16'h0003);
        @(posedge clk);
        #1 chk("rdata_idle", 16'(rdata), 16'h0000);
        rd(wddc_pkg::CHIP_DEC_ADDR, d);
        chk("chip_rst", 16'(d), 16'h0000);
        rd(12'h0ff, d);
        chk("unmapped", 16'(d), 16'h0000);
        chk("q_valid_rst", 16'(oqv), 16'h0001);
        $display("test reset done");
    endtask

    task automatic t_gain();
        dc_i <= 16'sd1000;
        dc_q <= 16'sd400;
        ramp <= 1'b0;
        wr(wddc_pkg::CHIP_DEC_ADDR, 8'h00);
        wr(wddc_pkg::CTRL_ADDR, 8'h00);
        soft_rst();
        repeat (100) @(posedge clk);
        chk("gain0_i", oi, 16'sd1000);
        chk("gain0_q", oq, 16'sd400);
        wr(wddc_pkg::CTRL_ADDR, 8'h04);
        soft_rst();
        repeat (100) @(posedge clk);
        chk("gain6_i", oi, 16'sd2000);
        chk("gain6_q", oq, 16'sd800);
        $display("test gain done");
    endtask

    task automatic run_cfg(input logic [7:0] ctl, input logic [7:0] cd,
                           input int ld);
        int r;
        logic [7:0] d;
        r = 1 << (ld - cd);
        dc_i <= 16'sd1000;
        dc_q <= 16'sd3000;
        ramp <= 1'b0;
        wr(wddc_pkg::CHIP_DEC_ADDR, cd);
        wr(wddc_pkg::CTRL_ADDR, ctl);
        soft_rst();
        ramp <= 1'b1;
        rd(wddc_pkg::STATUS_ADDR, d);
        chk("ratio", 16'(d[2:0]), 16'(ld));
        repeat (700) @(posedge clk);
        chk("q_valid", 16'(oqv), 16'(!ctl[3]));
        if (ctl[3]) chk("q_zero", oq, 16'h0000);
        chk("count", 16'(fr.si.size() >= 64), 16'h0001);
        for (int k = 1; k < 64; k++) begin
            chk("spacing", 16'(fr.st[k] - fr.st[k-1]), 16'(1 << cd));
            if (k % (2 * r) >= 2)
                chk("repeat", fr.si[k], fr.si[k-2]);
            else if (k >= 2)
                chk("advance", 16'(fr.si[k] !== fr.si[k-2]), 16'h1);
        end
        $display("test cfg %h %h done", ctl, cd);
    endtask

    task automatic t_nco();
        logic [7:0] d;
        dc_i <= 16'sd1000;
        dc_q <= 16'sd0;
        ramp <= 1'b0;
        wr(wddc_pkg::CHIP_DEC_ADDR, 8'h00);
        wr(wddc_pkg::NCO_LO_ADDR, 8'h00);
        wr(wddc_pkg::NCO_HI_ADDR, 8'h04);
        wr(wddc_pkg::CTRL_ADDR, 8'h10);
        soft_rst();
        rd(wddc_pkg::NCO_HI_ADDR, d);
        chk("nco_hi", 16'(d), 16'h0004);
        repeat (200) @(posedge clk);
        chk("nco_moved", 16'(oi !== 16'sd1000), 16'h1);
        $display("test nco done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gain();
        run_cfg(8'h00, 8'h00, 1);
        run_cfg(8'h01, 8'h00, 2);
        run_cfg(8'h02, 8'h01, 3);
        run_cfg(8'h03, 8'h02, 4);
        run_cfg(8'h08, 8'h00, 0);
        run_cfg(8'h09, 8'h00, 1);
        run_cfg(8'h0a, 8'h00, 2);
        run_cfg(8'h0b, 8'h03, 3);
        t_nco();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
